// [rtl/hasb_bridge.sv]
/*
  Sensor bridge: polls a three-axis sensor over SPI, median-decimates
  the samples into joystick reports, and runs host command reports as
  direct SPI exchanges; all through AHB-Lite registers.
  Assumes the USB stack firmware drives the bus, a single clock, and a
  sensor whose axis data sits in six bytes after the poll address.
*/
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "hasb_regs.svh"

module hasb_bridge #(
  parameter logic [15:0] SAMPLE_CYC = 16'(`HASB_SAMPLE_CYC), // Poll spacing
  parameter logic [7:0]  POLL_ADDR  = 8'h82                  // Poll address
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // SPI to the sensor
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  // Board pins
  input  wire logic [7:0]  button_inputs,
  input  wire logic        unmapped_mode_jumper
);
  import hasb_pkg::*;

  // ----------------------------------------
  // State and local wires
  // ----------------------------------------
  hasb_state_t      s, n;          // Registered state and its next value
  logic             fifo_in_rdy;   // Room for a sample
  logic             fifo_out_vld;  // Sample waiting for the filter
  logic [41:0]      fifo_out;      // Oldest sample
  hasb_sample_t     fifo_smp;      // Same, as a sample
  logic             start_poll;    // Poll may begin now
  logic             pub_now;       // Report being published
  logic [13:0]      a;             // Rank candidate
  logic [13:0]      b;             // Rank opponent
  logic [4:0]       ltn;           // Smaller count, this step included
  logic [4:0]       len;           // Not-larger count, this step included
  logic signed [14:0] v;           // Mapped value before clamping

  assign fifo_smp = hasb_sample_t'(fifo_out);
  assign pub_now  = (s.mst == MED_PUB);
  // Back-pressure: no poll unless the FIFO can take its sample
  assign start_poll = s.poll_due && !s.poll_dis && fifo_in_rdy;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout = 1'b1;         // Zero-wait slave
  assign hresp     = 1'b0;         // Always OKAY
  assign hrdata    = s.hrdata;
  assign spi_sclk  = s.sclk;
  assign spi_cs_n  = s.cs_n;
  assign spi_mosi  = s.tx[7];      // MSB first

  // ----------------------------------------
  // Sample buffer between SPI and filter
  // ----------------------------------------
  hasb_fifo #(
    .WIDTH ($bits(hasb_sample_t)),
    .DEPTH (`HASB_FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (s.push),
    .in_ready  (fifo_in_rdy),
    .in_data   (s.sample),
    .out_valid (fifo_out_vld),
    .out_ready (s.mst == MED_FILL),
    .out_data  (fifo_out)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    n   = s;
    a   = '0;
    b   = '0;
    ltn = '0;
    len = '0;
    v   = '0;
    // Pin synchronisers; first stage feeds only the second
    n.mi1  = spi_miso;
    n.mi2  = s.mi1;
    n.raw1 = unmapped_mode_jumper;
    n.raw2 = s.raw1;
    n.b1   = button_inputs;
    n.b2   = s.b1;
    // Low pin means contact closed, so pressed reads one
    n.btn  = ~s.b2;
    n.push = 1'b0;

    // Address phase: capture write, prepare read data
    n.a_wr  = hsel && hready && htrans[1] && hwrite;
    n.a_off = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      // Joystick words stand for function 0, command words for 1
      case (haddr[7:0])
        `HASB_OFF_CMD0: n.hrdata = s.cmd[3:0];
        `HASB_OFF_CMD1: n.hrdata = s.cmd[7:4];
        `HASB_OFF_RSP0: n.hrdata = s.rsp[3:0];
        `HASB_OFF_RSP1: n.hrdata = s.rsp[7:4];
        `HASB_OFF_STAT: n.hrdata = {16'h0000, s.seq, 4'h0, s.raw2,
                                    s.poll_dis, s.rsp_valid, s.cmd_busy};
        `HASB_OFF_JOY0: n.hrdata = {2'b00, s.joy[1], 2'b00, s.joy[0]};
        `HASB_OFF_JOY1: n.hrdata = {10'h000, s.btn, s.joy[2]};
        default:        n.hrdata = 32'h0000_0000;
      endcase
    end

    // Data phase: writes are refused while a command runs
    if (s.a_wr && !s.cmd_busy) begin
      case (s.a_off)
        // Header and first three payload bytes
        `HASB_OFF_CMD0: n.cmd[3:0] = hwdata;
        `HASB_OFF_CMD1: begin
          // Last four payload bytes; this write launches
          n.cmd[7:4]  = hwdata;
          n.cmd_busy  = 1'b1;
          n.cmd_pend  = 1'b1;
          n.rsp_valid = 1'b0;
          n.poll_dis  = s.cmd[0][`HASB_FLAG_BIT];
        end
        default: ;
      endcase
    end

    // SPI engine, mode 0, whole bytes only
    unique case (s.spi_st)
      SPI_IDLE: begin
        n.div  = `HASB_SCK_HALF;
        n.bitn = '0;
        n.idx  = '0;
        n.sclk = 1'b0;
        if (s.cmd_pend) begin
          // Commands win over polls
          n.cmd_pend = 1'b0;
          n.job      = JOB_CMD;
          n.total    = s.cmd[0][2:0];
          n.tx       = s.cmd[1];
          if (s.cmd[0][2:0] == 3'h0) begin
            n.spi_st = SPI_END;
          end else begin
            n.spi_st = SPI_RUN;
            n.cs_n   = 1'b0;
          end
        end else if (start_poll) begin
          n.poll_due = 1'b0;
          n.job      = JOB_POLL;
          n.total    = `HASB_POLL_LEN;
          n.tx       = POLL_ADDR;
          n.spi_st   = SPI_RUN;
          n.cs_n     = 1'b0;
        end
      end
      SPI_RUN: begin
        if (s.div != 4'h0) begin
          n.div = s.div - 4'h1;
        end else begin
          n.div = `HASB_SCK_HALF;
          if (!s.sclk) begin
            n.sclk = 1'b1;
          end else begin
            // Sample at the end of the high half, then shift
            n.sclk = 1'b0;
            n.rxsr = {s.rxsr[6:0], s.mi2};
            n.tx   = {s.tx[6:0], 1'b0};
            n.bitn = s.bitn + 3'h1;
            if (s.bitn == 3'h7) begin
              // One byte in for each byte out
              n.rx[s.idx] = {s.rxsr[6:0], s.mi2};
              if (s.idx == s.total - 3'h1) begin
                n.spi_st = SPI_END;
              end else begin
                n.idx = s.idx + 3'h1;
                n.tx  = (s.job == JOB_CMD) ? s.cmd[3'(s.idx + 3'h2)] : 8'h00;
              end
            end
          end
        end
      end
      SPI_END: begin
        n.cs_n   = 1'b1;
        n.spi_st = SPI_IDLE;
        if (s.job == JOB_CMD) begin
          // Count, then bytes as received; stale past the count
          n.rsp[0]    = {5'h00, s.total};
          n.rsp[7:1]  = s.rx;
          n.rsp_valid = 1'b1;
          n.cmd_busy  = 1'b0;
        end else begin
          // Axis bytes follow the address byte, low byte first
          n.push           = 1'b1;
          n.sample.axis[0] = {s.rx[2], s.rx[1][7:2]};
          n.sample.axis[1] = {s.rx[4], s.rx[3][7:2]};
          n.sample.axis[2] = {s.rx[6], s.rx[5][7:2]};
        end
      end
      default: n.spi_st = SPI_IDLE;
    endcase

    // Poll timer after the engine, so a fresh due beats the start's clear
    if (s.poll_cnt == SAMPLE_CYC - 16'h0001) begin
      n.poll_cnt = '0;
      n.poll_due = 1'b1;
    end else begin
      n.poll_cnt = s.poll_cnt + 16'h0001;
    end

    // Median filter: fill sixteen, rank, publish
    unique case (s.mst)
      MED_FILL: begin
        if (fifo_out_vld) begin
          n.mbuf[s.fill] = fifo_out;
          n.fill         = s.fill + 4'h1;
          if (s.fill == `HASB_MED_LAST) begin
            n.mst = MED_RANK;
            n.i   = '0;
            n.j   = '0;
            n.lt  = '0;
            n.le  = '0;
          end
        end
      end
      MED_RANK: begin
        // Count per axis how many samples lie below candidate i
        for (int ax = 0; ax < 3; ax++) begin
          // Axis k sits at bit 14k and up of a stored sample
          a   = s.mbuf[s.i][14*ax +: 14];
          b   = s.mbuf[s.j][14*ax +: 14];
          ltn = s.lt[ax] + 5'($signed(b) < $signed(a));
          len = s.le[ax] + 5'($signed(b) <= $signed(a));
          if (s.j == `HASB_MED_LAST) begin
            // Lower median: eighth smallest of sixteen
            if (ltn < `HASB_MED_MID && len >= `HASB_MED_MID) begin
              n.med.axis[ax] = a;
            end
            n.lt[ax] = '0;
            n.le[ax] = '0;
          end else begin
            n.lt[ax] = ltn;
            n.le[ax] = len;
          end
        end
        n.j = s.j + 4'h1;
        if (s.j == `HASB_MED_LAST) begin
          n.i = s.i + 4'h1;
          if (s.i == `HASB_MED_LAST) begin
            n.mst = MED_PUB;
          end
        end
      end
      MED_PUB: begin
        for (int ax = 0; ax < 3; ax++) begin
          a = s.med.axis[ax];
          // Y counts down, X and Z up, both around neutral
          v = (ax == 1) ? (`HASB_NEUTRAL - {a[13], a}) :
                          (`HASB_NEUTRAL + {a[13], a});
          if (s.raw2) begin
            n.joy[ax] = a;
          end else begin
            n.joy[ax] = v[14] ? 14'h0000 : v[13:0];
          end
        end
        n.seq = s.seq + 8'h01;
        n.mst = MED_FILL;
      end
      default: n.mst = MED_FILL;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s      <= '0;
      s.cs_n <= 1'b1;
      s.b1   <= 8'hff;
      s.b2   <= 8'hff;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_cs_idle_high: assert property (
    (s.spi_st == SPI_IDLE) |-> spi_cs_n)
    else $error("Chip select low while engine idle");

  a_rsp_count: assert property (
    (s.spi_st == SPI_END && s.job == JOB_CMD) |=>
      (s.rsp_valid && !s.cmd_busy && s.rsp[0] == {5'h00, $past(s.total)}))
    else $error("Response count differs from command count");

  a_zero_count: assert property (
    (s.spi_st == SPI_IDLE && s.cmd_pend && s.cmd[0][2:0] == 3'h0) |=>
      (s.spi_st == SPI_END) ##1 (s.rsp_valid && spi_cs_n))
    else $error("Empty command gave no response");

  a_flag_take: assert property (
    (s.a_wr && s.a_off == `HASB_OFF_CMD1 && !s.cmd_busy) |=>
      (s.cmd_busy && s.poll_dis == $past(s.cmd[0][`HASB_FLAG_BIT])))
    else $error("Disable flag not taken on launch");

  a_no_poll: assert property (
    (s.poll_dis && s.spi_st == SPI_IDLE && !s.cmd_pend) |=>
      (s.spi_st == SPI_IDLE))
    else $error("Poll started while disabled");

  a_map_zero: assert property (
    (pub_now && !s.raw2 && s.med.axis[0] == 14'h0000) |=>
      (s.joy[0] == 14'h1fff))
    else $error("Zero sample not mapped to neutral");

  a_y_invert: assert property (
    (pub_now && !s.raw2 && !s.med.axis[1][13]) |=>
      (s.joy[1] == 14'(`HASB_NEUTRAL - {1'b0, $past(s.med.axis[1])})))
    else $error("Y axis not inverted");

  a_raw_pass: assert property (
    (pub_now && s.raw2) |=> (s.joy == $past(s.med.axis)))
    else $error("Raw mode altered the sample");

  a_med_span: assert property (
    pub_now |-> ($past(s.mst, 256) == MED_RANK && $past(s.mst, 257) == MED_FILL))
    else $error("Report published without full ranking");

  a_btn_low: assert property (
    (s.b2 == 8'hff) [*2] |-> (s.btn == 8'h00))
    else $error("Released buttons read as pressed");
endmodule // hasb_bridge

// [rtl/hasb_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module hasb_fifo #(
  parameter int WIDTH = 42,  // Word width
  parameter int DEPTH = 32   // Words held
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage
    logic [AW:0]                 wr;   // Write pointer with wrap bit
    logic [AW:0]                 rd;   // Read pointer with wrap bit
  } hasb_fifo_st_t;
  hasb_fifo_st_t s, n;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((s.wr[AW] != s.rd[AW]) && (s.wr[AW-1:0] == s.rd[AW-1:0]));
  assign out_valid = (s.wr != s.rd);
  assign out_data  = s.mem[s.rd[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    n = s;
    if (in_valid && in_ready) begin
      n.mem[s.wr[AW-1:0]] = in_data;
      n.wr = s.wr + 1'b1;
    end
    if (out_valid && out_ready) begin
      n.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule // hasb_fifo

// [rtl/hasb_pkg.sv]
/*
  Types of the sensor bridge: state enums, sample carrier and the
  registered state of the bridge.
  Assumes nothing of its surroundings.
*/
package hasb_pkg;
  typedef enum logic [1:0] {SPI_IDLE, SPI_RUN, SPI_END} hasb_spi_st_t;
  typedef enum logic [1:0] {MED_FILL, MED_RANK, MED_PUB} hasb_med_st_t;
  typedef enum logic {JOB_POLL, JOB_CMD} hasb_job_t;

  // One three-axis sample, signed 14 bits each: 0 X, 1 Y, 2 Z
  typedef struct packed {
    logic [2:0][13:0] axis;
  } hasb_sample_t;

  typedef struct packed {
    logic a_wr; logic [7:0] a_off; logic [31:0] hrdata;
    logic [7:0][7:0] cmd; logic [7:0][7:0] rsp;
    logic cmd_pend; logic cmd_busy; logic rsp_valid; logic poll_dis;
    logic [15:0] poll_cnt; logic poll_due;
    hasb_spi_st_t spi_st; hasb_job_t job; logic sclk; logic cs_n;
    logic [3:0] div; logic [2:0] bitn; logic [2:0] idx; logic [2:0] total;
    logic [7:0] tx; logic [7:0] rxsr; logic [6:0][7:0] rx;
    logic push; hasb_sample_t sample;
    hasb_med_st_t mst; logic [3:0] fill; logic [15:0][41:0] mbuf;
    logic [3:0] i; logic [3:0] j; logic [2:0][4:0] lt; logic [2:0][4:0] le;
    hasb_sample_t med; logic [2:0][13:0] joy; logic [7:0] btn; logic [7:0] seq;
    logic mi1; logic mi2; logic raw1; logic raw2; logic [7:0] b1; logic [7:0] b2;
  } hasb_state_t;
endpackage

// [rtl/hasb_regs.svh]
/*
  Constants of the sensor bridge: register offsets, the command flag bit place,
  timing counts and sample mapping values.
  Assumes a 10 MHz hclk; included by bare name.
*/
`ifndef HASB_REGS_SVH
`define HASB_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HASB_OFF_CMD0   8'h00
`define HASB_OFF_CMD1   8'h04
`define HASB_OFF_RSP0   8'h08
`define HASB_OFF_RSP1   8'h0c
`define HASB_OFF_STAT   8'h10
`define HASB_OFF_JOY0   8'h14
`define HASB_OFF_JOY1   8'h18

// ----------------------------------------
// Timing and FIFO depth
// ----------------------------------------
`define HASB_CLK_MHZ    10
`define HASB_SAMPLE_US  500
`define HASB_SAMPLE_CYC (`HASB_SAMPLE_US * `HASB_CLK_MHZ)
`define HASB_SCK_HALF   4'h4
`define HASB_FIFO_DEPTH 32

// ----------------------------------------
// Filtering, mapping, poll length and command flag bit
// ----------------------------------------
`define HASB_MED_LAST   4'hf
`define HASB_MED_MID    5'h08
`define HASB_NEUTRAL    15'h1fff
`define HASB_POLL_LEN   3'h7
`define HASB_FLAG_BIT   7

`endif

// [testbench/hasb_bridge_tb.sv]
/*
  Self-checking bench of the sensor bridge: bus tasks, expected values
  worked out from integers, and the scenarios.
  Assumes the sensor model and the register constants header.
*/
`timescale 1ns/1ps
`include "hasb_regs.svh"
module hasb_bridge_tb;
  import hasb_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic            hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]     haddr, hwdata, hrdata, r;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic            spi_sclk, spi_cs_n, spi_mosi, spi_miso, jumper;
  logic [7:0]      btn;
  logic [6:0][7:0] reply, got, pl;
  logic [2:0][13:0] s;
  hasb_sample_t    smp;
  int              num_errors, num_checks, frames, nbytes, f;

  // Short poll spacing keeps the run brief
  hasb_bridge #(.SAMPLE_CYC(16'd200)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .button_inputs(btn), .unmapped_mode_jumper(jumper));

  hasb_sensor_model sens (
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .cmd_reply(reply), .sample(smp), .got(got), .frames(frames), .nbytes(nbytes));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hung;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    num_errors++;
    wrap_up;
  endtask

  // Joystick value expected for one axis, a = 0 X, 1 Y, 2 Z
  function automatic logic [13:0] exp_axis(logic [13:0] v, int a, logic raw);
    int x;
    x = $signed(v);
    if (raw)
      return v;
    x = (a == 1) ? 8191 - x : 8191 + x;
    return (x < 0) ? 14'h0000 : x[13:0];
  endfunction

  // ----------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int   n;
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, a};
    hwrite <= wr;
    n = 0;
    // Address phase holds until ready is seen high at a rising edge
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    // Data phase likewise; read data is taken at its closing edge
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100)
      hung;
  endtask

  // A write leaves one idle cycle so a following read sees it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(posedge hclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask

  // Waits until the report sequence has moved on by k
  task automatic wait_seq(input int k);
    logic [7:0] s0;
    int         n;
    rd(`HASB_OFF_STAT, r);
    s0 = r[15:8] + 8'(k);
    n  = 0;
    do begin
      rd(`HASB_OFF_STAT, r);
      n++;
    end while (r[15:8] !== s0 && n < 15000);
    if (n >= 15000)
      hung;
  endtask

  // Two whole reports after a change, so no window mixes old samples
  task automatic report(input logic [2:0][13:0] v, input logic raw);
    logic [31:0] j0, j1;
    smp    <= v;
    jumper <= raw;
    wait_seq(2);
    rd(`HASB_OFF_JOY0, j0);
    rd(`HASB_OFF_JOY1, j1);
    rd(`HASB_OFF_STAT, r);
    check(j0[13:0], exp_axis(v[0], 0, raw));
    check(j0[29:16], exp_axis(v[1], 1, raw));
    check(j1[13:0], exp_axis(v[2], 2, raw));
    check(r[3], raw);
  endtask

  // One command report and its response report
  task automatic cmd(input logic [7:0] hdr, input logic [6:0][7:0] p);
    logic [31:0] q0, q1;
    int          n, k, f0;
    n  = hdr[2:0];
    f0 = frames;
    wr(`HASB_OFF_CMD0, {p[2], p[1], p[0], hdr});
    wr(`HASB_OFF_CMD1, {p[6], p[5], p[4], p[3]});
    if (n == 7) begin
      // Refused while busy: the held report must stay as written
      wr(`HASB_OFF_CMD0, 32'hffff_ffff);
      rd(`HASB_OFF_CMD0, q0);
      check(q0, {p[2], p[1], p[0], hdr});
    end
    k = 0;
    do begin
      rd(`HASB_OFF_STAT, q0);
      k++;
    end while (q0[0] !== 1'b0 && k < 600);
    if (k >= 600)
      hung;
    check(q0[2:0], {hdr[7], 2'b10});
    rd(`HASB_OFF_RSP0, q0);
    rd(`HASB_OFF_RSP1, q1);
    check(q0[7:0], 8'(n));
    if (n > 0) begin
      check(frames - f0, 1);
      check(nbytes, n);
      for (k = 0; k < n; k++)
        check(got[k], p[k]);
      for (k = 1; k < n; k++)
        check((k < 3) ? q0[8*(k+1) +: 8] : q1[8*(k-3) +: 8], reply[k]);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b1;
    htrans     = 2'b00;
    haddr      = 32'h0000_0000;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0000_0000;
    btn        = 8'hff;
    jumper     = 1'b0;
    smp        = '0;
    reply      = '0;
    num_errors = 0;
    num_checks = 0;
    void'($urandom(92780));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check(spi_cs_n, 1'b1);
    check(spi_sclk, 1'b0);
    check(hrdata, 32'h0000_0000);
    check(hresp, 1'b0);
    @(posedge hclk);
    rd(8'h1c, r);
    check(r, 32'h0000_0000);
    rd(`HASB_OFF_STAT, r);
    check(r[3:0], 4'h0);
    rd(`HASB_OFF_JOY1, r);
    check(r[21:14], 8'h00);
    btn <= 8'($urandom);
    repeat (4) @(posedge hclk);
    rd(`HASB_OFF_JOY1, r);
    check(r[21:14], 8'(~btn));
    // Random, boundary and raw sample sets
    for (int i = 0; i < 3; i++) begin
      for (int a = 0; a < 3; a++)
        s[a] = (i == 1) ? ((a == 2) ? 14'h1fff : 14'h2000) : 14'($urandom_range(4000)) - 14'd2000;
      report(s, i == 2);
    end
    jumper <= 1'b0;
    cmd(8'h80, '0);
    for (int n = 1; n < 8; n++) begin
      for (int k = 0; k < 7; k++) begin
        reply[k] <= 8'($urandom);
        pl[k] = 8'($urandom);
      end
      pl[0][7] = 1'b0;
      @(posedge hclk);
      cmd({5'b1000_0, 3'(n)}, pl);
    end
    f = frames;
    repeat (1000) @(posedge hclk);
    check(frames, f);
    cmd(8'h00, '0);
    wait_seq(2);
    check(frames > f + 8, 1'b1);
    wrap_up;
  end
endmodule // hasb_bridge_tb

// [testbench/hasb_sensor_model.sv]
/*
  Behavioural three-axis sensor on the far side of the SPI link.
  Assumes mode 0, MSB first, and frames framed by an active-low select.
*/
`timescale 1ns/1ps
module hasb_sensor_model #(
  parameter logic [7:0] POLL_ADDR = 8'h82  // Address that marks a poll frame
) (
  // SPI from the bridge
  input  wire logic            spi_sclk,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_mosi,
  output logic                 spi_miso,
  // Bench control and observation
  input  wire logic [6:0][7:0] cmd_reply,
  input  wire hasb_pkg::hasb_sample_t sample,
  output logic [6:0][7:0]      got,
  output int                   frames,
  output int                   nbytes
);
  import hasb_pkg::*;
  logic [7:0] sh_in;   // Bits taken from the bridge
  logic [7:0] sh_out;  // Byte being sent back
  logic       poll;    // Current frame is a poll
  int         bitc;    // Clocks seen in this frame
  int         polls;   // Poll frames so far, sets the outlier phase

  // Every fourth poll carries an outlier, so a median of 16 ignores it
  function automatic logic [7:0] next_byte(int k);
    logic [13:0] s;
    if (k > 6)
      return 8'h00;
    if (!poll)
      return cmd_reply[k];
    s = sample.axis[(k-1)/2] ^ ((polls % 4 == 3) ? 14'h2000 : 14'h0000);
    return k[0] ? {s[5:0], 2'b00} : s[13:6];
  endfunction

  initial begin
    spi_miso = 1'b0;
    frames   = 0;
    nbytes   = 0;
    polls    = 0;
    poll     = 1'b0;
    bitc     = 0;
    got      = '0;
    sh_in    = 8'h00;
    sh_out   = 8'h00;
  end

  // Frame start: first bit stands before the first rising clock
  always @(negedge spi_cs_n) begin
    bitc     = 0;
    nbytes   = 0;
    poll     = 1'b0;
    sh_out   = cmd_reply[0];
    spi_miso = sh_out[7];
  end

  // Frame end: released line shows the inverse, never a stale bit
  always @(posedge spi_cs_n) begin
    if (bitc > 0) begin
      frames++;
      if (poll)
        polls++;
    end
    bitc     = 0;
    spi_miso = ~spi_miso;
  end

  // Sample on the rising edge, one byte in for each byte out
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      sh_in = {sh_in[6:0], spi_mosi};
      bitc++;
      if (bitc % 8 == 0 && nbytes < 7) begin
        got[nbytes] = sh_in;
        nbytes++;
        if (nbytes == 1 && sh_in == POLL_ADDR)
          poll = 1'b1;
      end
    end
  end

  // Shift on the falling edge so the high half stays stable
  always @(negedge spi_sclk) begin
    if (!spi_cs_n) begin
      sh_out   = (bitc % 8 == 0) ? next_byte(nbytes) : {sh_out[6:0], 1'b0};
      spi_miso = sh_out[7];
    end
  end
endmodule // hasb_sensor_model
